// ==== servo_status_defs.vh ====
// Constants for the servo status and encoder divider block
`ifndef SERVO_STATUS_DEFS_VH
`define SERVO_STATUS_DEFS_VH
// Register byte offsets
`define REG_CTRL        8'h00
`define REG_ZDEV_WIDTH  8'h04
`define REG_ZSPD_WIDTH  8'h08
`define REG_JUDGE_TIME  8'h0c
`define REG_BRAKE_TIME  8'h10
`define REG_PULSE_COUNT 8'h14
`define REG_Z_OFFSET    8'h18
`define REG_OUT_SEL     8'h1c
`define REG_STATUS      8'h20
// Control fields
`define CTRL_POS_MODE   0
`define CTRL_DIR_SWAP   1
`define CTRL_RESET      2'b01
// Setting ranges and reset values
`define ZDEV_MIN        32'd1
`define ZDEV_MAX        32'd20000
`define ZDEV_RESET      16'd400
`define ZSPD_MIN        32'd10
`define ZSPD_MAX        32'd5000
`define ZSPD_RESET      16'd50
`define JUDGE_MAX       32'd1000
`define JUDGE_RESET     16'd0
`define BRAKE_MAX       32'd999
`define BRAKE_RESET     16'd0
`define BRAKE_STEP_MS   14'd10
`define PCOUNT_MIN      32'd16
`define PCOUNT_MAX      32'd32768
`define PCOUNT_RESET    16'd2048
`define ZOFF_RESET      16'd0
`define OUT_SEL_RESET   16'h0000
// Terminal assignment codes
`define CODE_POS_DONE   4'h2
`define CODE_ZERO_DEV   4'h8
`define CODE_ZERO_SPD   4'h9
`define CODE_BRAKE      4'hb
// Encoder counts per revolution
`define ENC_PER_REV     18'h20000
// Timing
`define CLK_PERIOD_NS   100
`define MS_NS           1000000
`define MS_CYCLES       ((`MS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Bus responses
`define RESP_OKAY       2'b00
`define RESP_DECERR     2'b11
`endif

// ==== servo_status.v ====
// Servo status outputs, brake timing and divided encoder output
//
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`default_nettype none
`include "servo_status_defs.vh"

module servo_status #(
    parameter MS_CYCLES = `MS_CYCLES
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire        power_on_n,
    input  wire        ce,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [31:0] cmd_pos,
    input  wire [31:0] fb_pos,
    input  wire [15:0] motor_speed,
    input  wire        enc_step,
    input  wire        enc_fwd,
    input  wire        servo_run,
    input  wire        alarm,
    output reg  [3:0]  out_terminal,
    output reg         motor_hold,
    output reg         divided_phase_a,
    output reg         divided_phase_b,
    output reg         divided_index_n
);

    ////////////////////////////////////////////////////////////////////
    // Helpers
    function [15:0] clamp;
        input [31:0] v;
        input [31:0] lo;
        input [31:0] hi;
        begin
            if (v < lo)
                clamp = lo[15:0];
            else if (v > hi)
                clamp = hi[15:0];
            else
                clamp = v[15:0];
        end
    endfunction

    function [31:0] magnitude;
        input [31:0] v;
        begin
            magnitude = v[31] ? (~v + 32'd1) : v;
        end
    endfunction

    localparam LD_IDLE = 1'b0;
    localparam LD_RUN  = 1'b1;
    localparam BK_ENGAGED  = 2'd0;
    localparam BK_RELEASED = 2'd1;
    localparam BK_HOLD     = 2'd2;

    ////////////////////////////////////////////////////////////////////
    // Registers
    reg  [1:0]  ctrl;
    reg  [15:0] zdev_width;
    reg  [15:0] zspd_width;
    reg  [15:0] judge_time;
    reg  [15:0] brake_time;
    reg  [15:0] pcount_set;
    reg  [15:0] zoff_set;
    reg  [15:0] out_sel;
    reg  [7:0]  wr_addr;
    reg  [31:0] wr_data;
    reg         aw_held;
    reg         w_held;
    reg         zero_dev;
    reg         zero_spd;
    reg         pos_done;
    reg  [1:0]  brake_state;
    wire        brake_timing = (brake_state == BK_RELEASED);
    wire        wr_fire = aw_held && w_held && !s_axi_bvalid;
    wire        wr_hit;

    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready  = !w_held && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_hit = (wr_addr == `REG_CTRL) || (wr_addr == `REG_ZDEV_WIDTH) ||
                    (wr_addr == `REG_ZSPD_WIDTH) || (wr_addr == `REG_JUDGE_TIME) ||
                    (wr_addr == `REG_BRAKE_TIME) || (wr_addr == `REG_PULSE_COUNT) ||
                    (wr_addr == `REG_Z_OFFSET) || (wr_addr == `REG_OUT_SEL);

    // Write channel capture and response
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            wr_addr      <= 8'h00;
            wr_data      <= 32'h00000000;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RESP_OKAY;
        end else if (ce) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                wr_addr <= {s_axi_awaddr[7:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held  <= 1'b1;
                wr_data <= s_axi_wdata;
            end
            if (wr_fire) begin
                aw_held      <= 1'b0;
                w_held       <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_DECERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register writes; whole word taken only when all lanes are strobed
    always @(posedge aclk) begin
        if (!aresetn) begin
            ctrl       <= `CTRL_RESET;
            zdev_width <= `ZDEV_RESET;
            zspd_width <= `ZSPD_RESET;
            judge_time <= `JUDGE_RESET;
            brake_time <= `BRAKE_RESET;
            out_sel    <= `OUT_SEL_RESET;
        end else if (ce && wr_fire && (s_axi_wstrb == 4'hf)) begin
            case (wr_addr)
                `REG_CTRL:       ctrl <= wr_data[1:0];
                `REG_ZDEV_WIDTH: zdev_width <= clamp(wr_data, `ZDEV_MIN, `ZDEV_MAX);
                `REG_ZSPD_WIDTH: zspd_width <= clamp(wr_data, `ZSPD_MIN, `ZSPD_MAX);
                `REG_JUDGE_TIME: judge_time <= clamp(wr_data, 32'd0, `JUDGE_MAX);
                `REG_BRAKE_TIME: brake_time <= clamp(wr_data, 32'd0, `BRAKE_MAX);
                `REG_OUT_SEL:    out_sel <= wr_data[15:0];
                default:         ctrl <= ctrl;
            endcase
        end
    end

    // Power-held settings, set to their reset values only at power-on
    always @(posedge aclk) begin
        if (!power_on_n) begin
            pcount_set <= `PCOUNT_RESET;
            zoff_set   <= `ZOFF_RESET;
        end else if (ce && wr_fire && (s_axi_wstrb == 4'hf)) begin
            if (wr_addr == `REG_PULSE_COUNT)
                pcount_set <= clamp(wr_data, `PCOUNT_MIN, `PCOUNT_MAX);
            if (wr_addr == `REG_Z_OFFSET)
                zoff_set <= wr_data[15:0];
        end
    end

    // Read channel
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h00000000;
            s_axi_rresp  <= `RESP_OKAY;
        end else if (ce) begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `RESP_OKAY;
                case ({s_axi_araddr[7:2], 2'b00})
                    `REG_CTRL:        s_axi_rdata <= {30'h0, ctrl};
                    `REG_ZDEV_WIDTH:  s_axi_rdata <= {16'h0, zdev_width};
                    `REG_ZSPD_WIDTH:  s_axi_rdata <= {16'h0, zspd_width};
                    `REG_JUDGE_TIME:  s_axi_rdata <= {16'h0, judge_time};
                    `REG_BRAKE_TIME:  s_axi_rdata <= {16'h0, brake_time};
                    `REG_PULSE_COUNT: s_axi_rdata <= {16'h0, pcount_set};
                    `REG_Z_OFFSET:    s_axi_rdata <= {16'h0, zoff_set};
                    `REG_OUT_SEL:     s_axi_rdata <= {16'h0, out_sel};
                    `REG_STATUS:      s_axi_rdata <= {26'h0, alarm, motor_hold,
                                                     brake_timing, pos_done,
                                                     zero_spd, zero_dev};
                    default: begin
                        s_axi_rdata <= 32'h00000000;
                        s_axi_rresp <= `RESP_DECERR;
                    end
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Millisecond tick
    reg  [31:0] ms_div;
    wire        ms_tick = (ms_div == MS_CYCLES - 1);

    always @(posedge aclk) begin
        if (!aresetn)
            ms_div <= 32'h00000000;
        else if (ce)
            ms_div <= ms_tick ? 32'h00000000 : ms_div + 32'd1;
    end

    ////////////////////////////////////////////////////////////////////
    // Status flags and positioning complete
    reg  [15:0] judge_cnt;
    wire [31:0] dev_mag = magnitude(cmd_pos - fb_pos);
    wire [31:0] spd_mag = magnitude({{16{motor_speed[15]}}, motor_speed});
    wire        settled = zero_dev && zero_spd && !alarm;

    always @(posedge aclk) begin
        if (!aresetn) begin
            zero_dev  <= 1'b1;
            zero_spd  <= 1'b0;
            pos_done  <= 1'b0;
            judge_cnt <= 16'h0000;
        end else if (ce) begin
            zero_dev <= !ctrl[`CTRL_POS_MODE] || (dev_mag <= {16'h0, zdev_width});
            zero_spd <= (spd_mag <= {16'h0, zspd_width});
            if (!settled) begin
                judge_cnt <= 16'h0000;
                pos_done  <= 1'b0;
            end else begin
                if (ms_tick && (judge_cnt < judge_time))
                    judge_cnt <= judge_cnt + 16'd1;
                pos_done <= (judge_cnt >= judge_time);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Brake timing and post-release hold
    reg  [13:0] brake_ms;
    wire [13:0] brake_limit = brake_time[9:0] * `BRAKE_STEP_MS;

    always @(posedge aclk) begin
        if (!aresetn) begin
            brake_state <= BK_ENGAGED;
            brake_ms    <= 14'h0000;
            motor_hold  <= 1'b0;
        end else if (ce) begin
            case (brake_state)
                BK_ENGAGED: begin
                    if (servo_run && !alarm)
                        brake_state <= BK_RELEASED;
                end
                BK_RELEASED: begin
                    brake_ms <= 14'h0000;
                    if (alarm)
                        brake_state <= BK_ENGAGED;
                    else if (!servo_run)
                        brake_state <= BK_HOLD;
                end
                BK_HOLD: begin
                    // torque held until brake has engaged
                    if (alarm || (brake_ms >= brake_limit))
                        brake_state <= BK_ENGAGED;
                    else if (ms_tick)
                        brake_ms <= brake_ms + 14'd1;
                end
                default: brake_state <= BK_ENGAGED;
            endcase
            // Torque kept through the run-off edge, no one-cycle dip
            motor_hold <= !alarm && (servo_run || (brake_state != BK_ENGAGED));
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Terminal routing
    function route;
        input [3:0] code;
        input       dev;
        input       spd;
        input       done;
        input       brk;
        begin
            case (code)
                `CODE_POS_DONE: route = done;
                `CODE_ZERO_DEV: route = dev;
                `CODE_ZERO_SPD: route = spd;
                `CODE_BRAKE:    route = brk;
                default:        route = 1'b0;
            endcase
        end
    endfunction

    integer t;

    always @(posedge aclk) begin
        if (!aresetn) begin
            out_terminal <= 4'h0;
        end else if (ce) begin
            for (t = 0; t < 4; t = t + 1)
                out_terminal[t] <= route(out_sel[4*t +: 4], zero_dev, zero_spd,
                                         pos_done, brake_timing);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Divider settings loaded after reset
    reg         ld_state;
    reg  [15:0] pcount;
    reg  [16:0] z_rem;
    reg  [15:0] z_cycle;

    always @(posedge aclk) begin
        if (!aresetn) begin
            ld_state <= LD_RUN;
            pcount   <= `PCOUNT_RESET;
            z_rem    <= 17'h00000;
            z_cycle  <= 16'h0000;
        end else if (ce) begin
            case (ld_state)
                LD_RUN: begin
                    // power-held count loaded; offset reduced to one revolution, ignored if the count is 2048
                    pcount <= pcount_set;
                    if (pcount != pcount_set)
                        z_rem <= {zoff_set, 1'b0};
                    else if (z_rem >= {1'b0, pcount})
                        z_rem <= z_rem - {1'b0, pcount};
                    else begin
                        z_cycle  <= z_rem[15:0];
                        ld_state <= LD_IDLE;
                    end
                end
                default: ld_state <= LD_IDLE;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Rate accumulator and quadrature position
    reg  [16:0] acc;
    reg  [1:0]  quad;
    reg  [15:0] cyc;
    wire [17:0] inc = {pcount, 2'b00};
    wire [17:0] sum_up = {1'b0, acc} + inc;
    // Wrapped accumulator values, cut to width on purpose
    wire [17:0] up_wrap = sum_up - `ENC_PER_REV;
    wire [17:0] dn_wrap = {1'b0, acc} + `ENC_PER_REV - inc;
    wire [17:0] dn_step = {1'b0, acc} - inc;
    wire        run_div = (ld_state == LD_IDLE) && enc_step;

    always @(posedge aclk) begin
        if (!aresetn) begin
            acc  <= 17'h00000;
            quad <= 2'b00;
            cyc  <= 16'h0000;
        end else if (ce && run_div) begin
            // scale feedback counts to output edges
            if (enc_fwd) begin
                if (sum_up >= `ENC_PER_REV) begin
                    acc  <= up_wrap[16:0];
                    quad <= quad + 2'd1;
                    if (quad == 2'd3)
                        cyc <= (cyc == pcount - 16'd1) ? 16'h0000 : cyc + 16'd1;
                end else begin
                    acc <= sum_up[16:0];
                end
            end else begin
                if ({1'b0, acc} < inc) begin
                    acc  <= dn_wrap[16:0];
                    quad <= quad - 2'd1;
                    if (quad == 2'd0)
                        cyc <= (cyc == 16'h0000) ? pcount - 16'd1 : cyc - 16'd1;
                end else begin
                    acc <= dn_step[16:0];
                end
            end
        end
    end

    // Output phases and index
    wire pa = quad[1];
    wire pb = quad[1] ^ quad[0];
    wire a_out = ctrl[`CTRL_DIR_SWAP] ? pb : pa;

    always @(posedge aclk) begin
        if (!aresetn) begin
            divided_phase_a <= 1'b0;
            divided_phase_b <= 1'b0;
            divided_index_n <= 1'b1;
        end else if (ce) begin
            // gray order, B leads A forward unless swapped
            divided_phase_a <= a_out;
            divided_phase_b <= ctrl[`CTRL_DIR_SWAP] ? pa : pb;
            // index during A high of the offset cycle
            divided_index_n <= !((cyc == z_cycle) && a_out);
        end
    end

endmodule
`default_nettype wire

// ==== servo_status_checker_properties.sv ====
// Port checker for the servo status and divider block
`default_nettype none
module servo_status_checker #(
    parameter MS_CYCLES = 10000
) (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        ce,
    input wire logic        alarm,
    input wire logic        enc_step,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        motor_hold,
    input wire logic        divided_phase_a,
    input wire logic        divided_phase_b,
    input wire logic        divided_index_n
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////
    // Status and divider outputs
    a_alarm_drops_hold: assert property (ce && alarm |=> !motor_hold)
        else $error("hold torque kept after alarm");
    a_quad_one_edge: assert property (!($changed(divided_phase_a) && $changed(divided_phase_b)))
        else $error("both phases moved together");
    a_edge_needs_step: assert property
        ($changed(divided_phase_a) || $changed(divided_phase_b) |-> $past(enc_step, 2))
        else $error("phase edge without encoder step");
    a_index_with_a: assert property (!divided_index_n |-> divided_phase_a)
        else $error("index low while phase a low");
    a_index_on_a: assert property ($changed(divided_index_n) |-> $changed(divided_phase_a))
        else $error("index edge off phase a edge");
    ////////////////////////////////////////////////
    // Register bus handshakes and clock-enable freeze
    a_read_answer: assert property (ce && s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_rdata_stands: assert property
        (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_bresp_stands: assert property
        (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_write_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    a_ce_freezes: assert property (!ce |=> $stable(motor_hold) && $stable(divided_index_n)
        && $stable(s_axi_bvalid) && $stable(s_axi_rvalid))
        else $error("state moved with clock enable low");
    // Main scenarios reached
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (!divided_index_n);
    cover property (alarm && motor_hold);
    cover property ($rose(divided_phase_b));
endmodule
bind servo_status servo_status_checker #(.MS_CYCLES(MS_CYCLES)) chk (
    .aclk(aclk), .aresetn(aresetn), .ce(ce), .alarm(alarm), .enc_step(enc_step),
    .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .motor_hold(motor_hold), .divided_phase_a(divided_phase_a),
    .divided_phase_b(divided_phase_b), .divided_index_n(divided_index_n));
`default_nettype wire

// ==== host_counter.sv ====
// Host controller model counting the divided quadrature output
`default_nettype none
module host_counter (
    input wire logic aclk,
    input wire logic rst_n,
    input wire logic a,
    input wire logic b,
    input wire logic z_n,
    output var int   pos,
    output var int   n_index,
    output var int   n_bad
);
    logic [1:0] last;
    logic       last_z;
    // Decode phase pairs into a signed position
    always @(posedge aclk) begin
        last <= {a, b};
        last_z <= z_n;
        if (!rst_n) begin
            pos <= 0;
            n_index <= 0;
            n_bad <= 0;
        end else begin
            case ({last, a, b})
                4'b0001, 4'b0111, 4'b1110, 4'b1000: pos <= pos + 1;
                4'b0100, 4'b1101, 4'b1011, 4'b0010: pos <= pos - 1;
                4'b0000, 4'b0101, 4'b1111, 4'b1010: ;
                default: n_bad <= n_bad + 1;
            endcase
            if (last_z && !z_n) n_index <= n_index + 1;
        end
    end
endmodule
`default_nettype wire

// ==== servo_status_test.sv ====
// Self-checking bench for the servo status and divider block
`default_nettype none
`include "servo_status_defs.vh"
module servo_status_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic        aclk = 0, aresetn = 0, power_on_n = 0, awvalid = 0, wvalid = 0, bready = 0;
    logic        arvalid = 0, rready = 0, enc_step = 0, enc_fwd = 1, servo_run = 0, alarm = 0;
    logic        ce = 1;
    logic [3:0]  wstrb = 4'hf;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, cmd_pos = 0, fb_pos = 0, lfsr = 32'h30b86c37;
    logic [15:0] motor_speed = 0;
    logic        awready, wready, bvalid, arready, rvalid, hold, pa, pb, zn;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [3:0]  term;
    int          n_fail = 0, compares = 0, cyc = 0, hpos, hidx, hbad, expos, exidx, inz, wasz;
    int          regm [0:8] = '{1, 400, 50, 0, 0, 2048, 0, 0, 0};
    int          lo [0:8] = '{0, 1, 10, 0, 0, 16, 0, 0, 0};
    int          hi [0:8] = '{3, 20000, 5000, 1000, 999, 32768, 65535, 65535, 0};
    int          dv [6] = '{131, 132, -131, -132, 0, 0};
    int          sv [6] = '{0, 0, 50, 51, -50, -51};
    servo_status #(.MS_CYCLES(4)) uut (
        .aclk(aclk), .aresetn(aresetn), .power_on_n(power_on_n), .ce(ce),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .cmd_pos(cmd_pos), .fb_pos(fb_pos), .motor_speed(motor_speed), .enc_step(enc_step),
        .enc_fwd(enc_fwd), .servo_run(servo_run), .alarm(alarm), .out_terminal(term),
        .motor_hold(hold), .divided_phase_a(pa), .divided_phase_b(pb), .divided_index_n(zn));
    host_counter hc (.aclk(aclk), .rst_n(aresetn), .a(pa), .b(pb), .z_n(zn),
        .pos(hpos), .n_index(hidx), .n_bad(hbad));
    ////////////////////////////////////////////////
    // Clock and hang guard
    always #50 aclk = ~aclk;
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////
    // Compare, verdict and bus tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic finish_test();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Next value of the random source
    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction
    task automatic wr(input logic [7:0] a, input int d);
        int i;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 0;
            if (wvalid && wready) wvalid <= 0;
            if (bvalid) break;
        end
        bready <= 0;
        chk("bresp", (a <= `REG_OUT_SEL) ? `RESP_OKAY : `RESP_DECERR, bresp);
        i = a >> 2;
        if (a <= `REG_OUT_SEL && wstrb == 4'hf)
            regm[i] = d < lo[i] ? lo[i] : (d > hi[i] ? hi[i] : d);
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a; arvalid <= 1; rready <= 1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 0;
            if (rvalid) break;
        end
        rready <= 0;
        chk("rresp", (a <= `REG_OUT_SEL) ? `RESP_OKAY : `RESP_DECERR, rresp);
        chk("rdata", (a <= `REG_OUT_SEL) ? regm[a >> 2] : 0, rdata);
    endtask
    // Drive position error and speed, then check both flags
    task automatic st(input int d, input int s);
        logic zd, zs;
        @(posedge aclk);
        cmd_pos <= 1000 + d; fb_pos <= 1000; motor_speed <= 16'(s);
        repeat (3) @(posedge aclk);
        zd = (regm[0] % 2 == 0) || ((d < 0 ? -d : d) <= regm[1]);
        zs = (s < 0 ? -s : s) <= regm[2];
        chk("zero_dev", {31'd0, zd}, {31'd0, term[0]});
        chk("zero_spd", {31'd0, zs}, {31'd0, term[1]});
    endtask
    ////////////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (6) @(posedge aclk);
        aresetn <= 1; power_on_n <= 1;
        for (int i = 0; i < 8; i++) rd(8'(i * 4));
        rd(8'h40);
        wr(`REG_STATUS, 0);
        wr(`REG_ZDEV_WIDTH, 0);
        rd(`REG_ZDEV_WIDTH);
        wr(`REG_ZSPD_WIDTH, 6000);
        rd(`REG_ZSPD_WIDTH);
        // Partial strobe leaves the register as it was
        wstrb <= 4'h3;
        wr(`REG_ZDEV_WIDTH, 200);
        wstrb <= 4'hf;
        rd(`REG_ZDEV_WIDTH);
        wr(`REG_ZDEV_WIDTH, 131);
        wr(`REG_ZSPD_WIDTH, 50);
        wr(`REG_OUT_SEL, 32'h2b98);
        for (int i = 0; i < 6; i++) st(dv[i], sv[i]);
        // Clock enable low freezes the flags
        ce <= 0;
        cmd_pos <= 32'd9000;
        repeat (3) @(posedge aclk);
        chk("frozen zero_dev", 1, {31'd0, term[0]});
        ce <= 1;
        wr(`REG_CTRL, 0);
        st(5000, 0);
        wr(`REG_CTRL, 1);
        // Judgment time holds off positioning complete
        wr(`REG_JUDGE_TIME, 2);
        st(132, 0);
        st(0, 0);
        chk("pos_done early", 0, {31'd0, term[3]});
        for (int i = 0; i < 40 && !term[3]; i++) @(posedge aclk);
        chk("pos_done", 1, {31'd0, term[3]});
        // Brake hold after run off, then alarm
        wr(`REG_BRAKE_TIME, 1);
        servo_run <= 1;
        repeat (3) @(posedge aclk);
        chk("brake on", 1, {31'd0, term[2]});
        servo_run <= 0;
        repeat (20) @(posedge aclk);
        chk("hold in brake time", 1, {31'd0, hold});
        repeat (30) @(posedge aclk);
        chk("hold after brake time", 0, {31'd0, hold});
        servo_run <= 1;
        repeat (3) @(posedge aclk);
        alarm <= 1;
        repeat (3) @(posedge aclk);
        chk("brake on alarm", 0, {31'd0, term[2]});
        alarm <= 0; servo_run <= 0;
        // Power-on sets the held count back to 2048; a reset then applies a new one
        wr(`REG_PULSE_COUNT, 100);
        power_on_n <= 0;
        @(posedge aclk);
        power_on_n <= 1;
        regm[5] = 2048;
        rd(`REG_PULSE_COUNT);
        wr(`REG_PULSE_COUNT, 32768);
        // Random steps both ways, plain then with phases swapped
        for (int sw = 0; sw < 2; sw++) begin
            aresetn <= 0;
            repeat (2) @(posedge aclk);
            aresetn <= 1;
            repeat (10) @(posedge aclk);
            wr(`REG_CTRL, 1 + 2 * sw);
            expos = 0;
            exidx = 0;
            wasz = 0;
            // host steps slowly through the index window
            for (int i = 0; i < 300; i++) begin
                lfsr = lfsr_next(lfsr);
                enc_step <= lfsr[0]; enc_fwd <= (i < 200);
                if (lfsr[0]) expos += (i < 200) ? 1 : -1;
                // Index low while A is high in output pulse 0
                inz = (expos == 2 - sw) || (expos == 3 - sw);
                if (inz && !wasz) exidx++;
                wasz = inz;
                @(posedge aclk);
            end
            enc_step <= 0;
            repeat (6) @(posedge aclk);
            chk("host position", sw ? -expos : expos, hpos);
            chk("bad transitions", 0, hbad);
            chk("index pulses", exidx, hidx);
        end
        finish_test();
    end
endmodule
`default_nettype wire
